// ===== shared/i2c_maps_pkg.sv
// constants shared by the multi-map serial slave port and its bit engine
// assumes: all users are clocked by one system clock; nothing is imported
package i2c_maps_pkg;
	// ==========================================================
	// map indexes into the shared byte store
	localparam logic [2:0] MAP_IO = 3'h0;
	localparam logic [2:0] MAP_PROCESSOR = 3'h1;
	localparam logic [2:0] MAP_LINK_RX = 3'h2;
	localparam logic [2:0] MAP_REPEATER = 3'h3;
	localparam logic [2:0] MAP_DISPLAY_ID = 3'h4;
	localparam logic [2:0] MAP_PACKET_FRAME = 3'h5;
	localparam logic [2:0] MAP_SPARE = 3'h6;
	localparam logic [2:0] MAP_PLL = 3'h7;

	// ==========================================================
	// device-address registers inside the io map
	localparam logic [7:0] OFS_SPARE_MAP = 8'hF4;
	localparam logic [7:0] OFS_PACKET_FRAME_MAP = 8'hF5;
	localparam logic [7:0] OFS_PLL_MAP = 8'hF8;
	localparam logic [7:0] OFS_REPEATER_MAP = 8'hF9;
	localparam logic [7:0] OFS_DISPLAY_ID_MAP = 8'hFA;
	localparam logic [7:0] OFS_LINK_RX_MAP = 8'hFB;
	localparam logic [7:0] OFS_PROCESSOR_MAP = 8'hFD;
	localparam int ADDR_FIELD_LSB = 1; // address field sits in bits 7 to 1
	localparam logic [6:0] ADDR_RESET = 7'h00; // zero keeps the map silent
	localparam logic ADDR_PAD = 1'b0; // bit 0 of an address register reads zero

	// ==========================================================
	// bus addresses, seven-bit form
	localparam logic [6:0] IO_DEVICE_ADDRESS = 7'h4C; // 0x98 on the wire
	localparam logic [6:0] CHANNEL_ID_ADDRESS = 7'h50; // 0xA0 on the wire
	localparam logic [6:0] CHANNEL_PROTECT_ADDRESS = 7'h3A; // 0x74 on the wire

	// ==========================================================
	// map geometry and channel-port behaviour
	localparam logic [7:0] MAP_TOP = 8'hFF; // highest subaddress of each map
	localparam logic [7:0] SHORT_READ_START = 8'h08; // plain default
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// ==========================================================
	// bit engine counts
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_FIRST = 4'h0;
	localparam logic [3:0] BIT_STEP = 4'h1;
endpackage

// ===== src/serial_bit_engine.sv
// bit-level slave engine for one two-wire port: conditions, bytes, acknowledge
// assumes: pins are asynchronous to clk; the parent decides ack and supplies read data
`timescale 1ns/100ps
module serial_bit_engine
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic scl_pin,
	input wire logic sda_pin,
	input wire logic ack_en,
	input wire logic [7:0] tx_byte,
	output logic sda_out,
	output logic sda_oe,
	output logic start_evt,
	output logic stop_evt,
	output logic byte_evt,
	output logic first_byte,
	output logic [7:0] rx_byte,
	output logic tx_done
);
	typedef enum logic [2:0] {st_idle, st_rx, st_ack, st_tx, st_mack} engine_state_t;

	engine_state_t state;
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic scl_q;
	logic sda_q;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic dir_read;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;

	// ==========================================================
	// pin synchronisers; stage 0 feeds stage 1 only
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else if (ce)
		begin
			scl_sync <= {scl_sync[0], scl_pin};
			sda_sync <= {sda_sync[0], sda_pin};
			scl_q <= scl_sync[1];
			sda_q <= sda_sync[1];
		end

	// edges and bus conditions, seen with clock high on both samples
	assign scl_rise = scl_sync[1] & ~scl_q;
	assign scl_fall = ~scl_sync[1] & scl_q;
	assign start_c = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
	assign stop_c = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];

	// ==========================================================
	// byte sequencer; conditions override every state
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			state <= st_idle;
			bit_cnt <= i2c_maps_pkg::BIT_FIRST;
			shift <= i2c_maps_pkg::BYTE_RESET;
			rx_byte <= i2c_maps_pkg::BYTE_RESET;
			dir_read <= 1'b0;
			first_byte <= 1'b0;
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
		end
		else if (ce)
		begin
			sda_out <= 1'b0; // open drain: only ever pulls low
			if (stop_c || start_c)
			begin
				state <= start_c ? st_rx : st_idle;
				bit_cnt <= i2c_maps_pkg::BIT_FIRST;
				first_byte <= start_c;
				dir_read <= 1'b0;
				sda_oe <= 1'b0;
			end
			else
				unique case (state)
				st_idle:
					sda_oe <= 1'b0;
				st_rx:
					if (scl_rise)
					begin
						shift <= {shift[6:0], sda_sync[1]};
						bit_cnt <= bit_cnt + i2c_maps_pkg::BIT_STEP;
						if (bit_cnt == i2c_maps_pkg::BIT_LAST)
							rx_byte <= {shift[6:0], sda_sync[1]};
						if (bit_cnt == i2c_maps_pkg::BIT_LAST && first_byte)
							dir_read <= sda_sync[1];
					end
					else if (scl_fall && bit_cnt == i2c_maps_pkg::BIT_ACK)
					begin
						// refusal releases the line and waits for the next start
						sda_oe <= ack_en;
						state <= ack_en ? st_ack : st_idle;
					end
				st_ack:
					if (scl_fall)
					begin
						first_byte <= 1'b0;
						bit_cnt <= i2c_maps_pkg::BIT_FIRST;
						shift <= tx_byte;
						sda_oe <= dir_read & ~tx_byte[7];
						state <= dir_read ? st_tx : st_rx;
					end
				st_tx:
					if (scl_fall)
					begin
						bit_cnt <= bit_cnt + i2c_maps_pkg::BIT_STEP;
						shift <= {shift[6:0], 1'b0};
						sda_oe <= (bit_cnt == i2c_maps_pkg::BIT_LAST) ? 1'b0 : ~shift[6];
						if (bit_cnt == i2c_maps_pkg::BIT_LAST)
							state <= st_mack;
					end
				st_mack:
					if (scl_rise && sda_sync[1])
						state <= st_idle;
					else if (scl_fall)
					begin
						bit_cnt <= i2c_maps_pkg::BIT_FIRST;
						shift <= tx_byte;
						sda_oe <= ~tx_byte[7];
						state <= st_tx;
					end
				endcase
		end

	// ==========================================================
	// one-cycle event pulses for the parent
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			start_evt <= 1'b0;
			stop_evt <= 1'b0;
			byte_evt <= 1'b0;
			tx_done <= 1'b0;
		end
		else if (ce)
		begin
			start_evt <= start_c;
			stop_evt <= stop_c;
			byte_evt <= ~start_c & ~stop_c & scl_rise & (state == st_rx)
				& (bit_cnt == i2c_maps_pkg::BIT_LAST);
			tx_done <= ~start_c & ~stop_c & scl_rise & (state == st_mack);
		end
endmodule

// ===== src/multi_map_i2c_slave_port.sv
// multi-map two-wire slave: main port with eight 256-byte maps, one channel port
// assumes: pins are open drain with external pull-ups; scl is never stretched
// Summary of operation
// - Zero address register keeps map silent.
// - Nonzero address register makes map answer.
// - Start is data falling while clock high.
// - Eight bits MSB first: address, direction.
// - Match acknowledges; mismatch releases and idles.
// - Direction bit zero writes, one reads.
// - Second byte is subaddress; then auto-increment.
// - Stop closes transfer; single registers allowed.
// - Start anywhere restarts address phase; stop forces idle.
// - Invalid subaddress gets no acknowledge, idle.
// - Reads past top repeat highest register.
// - Writes past top discarded, nacked, idle.
// - Channel port supports current-address reads.
// - Channel counter tracks and increments per access.
// - Id data read-only 0xA0, protection 0x74.
// - Protection area supports short read format.
// - Main port serves eight independent 256-byte maps.
`timescale 1ns/100ps
module multi_map_i2c_slave_port
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic serial_clock,
	input wire logic serial_data_in,
	output logic serial_data_out,
	output logic serial_data_oe,
	input wire logic first_channel_port_clock,
	input wire logic first_channel_port_data_in,
	output logic first_channel_port_data_out,
	output logic first_channel_port_data_oe
);
	// ==========================================================
	// decoding helpers

	// bus address to {hit, map index}; a zero register never matches
	function automatic logic [3:0] match_map(input logic [6:0] dev,
		input logic [7:1][6:0] tbl);
		logic [3:0] hit;
		hit = 4'h0;
		if (dev == i2c_maps_pkg::IO_DEVICE_ADDRESS)
			hit = {1'b1, i2c_maps_pkg::MAP_IO};
		for (int i = 1; i < 8; i++)
			if (tbl[i] != i2c_maps_pkg::ADDR_RESET && tbl[i] == dev)
				hit = {1'b1, 3'(i)};
		return hit;
	endfunction

	// io-map subaddress to {hit, map whose address register it is}
	function automatic logic [3:0] offset_to_map(input logic [7:0] sub);
		logic [3:0] hit;
		hit = 4'h0;
		unique case (sub)
			i2c_maps_pkg::OFS_PROCESSOR_MAP: hit = {1'b1, i2c_maps_pkg::MAP_PROCESSOR};
			i2c_maps_pkg::OFS_LINK_RX_MAP: hit = {1'b1, i2c_maps_pkg::MAP_LINK_RX};
			i2c_maps_pkg::OFS_REPEATER_MAP: hit = {1'b1, i2c_maps_pkg::MAP_REPEATER};
			i2c_maps_pkg::OFS_DISPLAY_ID_MAP: hit = {1'b1, i2c_maps_pkg::MAP_DISPLAY_ID};
			i2c_maps_pkg::OFS_PACKET_FRAME_MAP: hit = {1'b1, i2c_maps_pkg::MAP_PACKET_FRAME};
			i2c_maps_pkg::OFS_SPARE_MAP: hit = {1'b1, i2c_maps_pkg::MAP_SPARE};
			i2c_maps_pkg::OFS_PLL_MAP: hit = {1'b1, i2c_maps_pkg::MAP_PLL};
			default: hit = 4'h0;
		endcase
		return hit;
	endfunction

	// every map is fully populated; kept per map so a smaller one can be cut
	function automatic logic [7:0] map_top(input logic [2:0] idx);
		logic [7:0] top;
		top = i2c_maps_pkg::MAP_TOP;
		if (idx == i2c_maps_pkg::MAP_IO)
			top = i2c_maps_pkg::MAP_TOP;
		return top;
	endfunction

	// ==========================================================
	// storage: eight maps of 256 bytes in one array, plus address registers
	logic [7:0] map_mem [0:2047];
	logic [7:1][6:0] map_address;

	// ==========================================================
	// main port engine and its transfer state
	logic m_start;
	logic m_stop;
	logic m_byte;
	logic m_first;
	logic [7:0] m_rx;
	logic m_done;
	logic m_ack;
	logic [7:0] m_tx;
	logic [2:0] m_map;
	logic [7:0] m_ptr;
	logic m_need_sub;
	logic m_over;
	logic [3:0] m_hit;
	logic [3:0] m_ofs;
	logic m_wr;
	logic m_reg_we;
	logic m_mem_we;
	logic [7:0] m_rd_byte;

	serial_bit_engine main_engine
	(
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.scl_pin(serial_clock),
		.sda_pin(serial_data_in),
		.ack_en(m_ack),
		.tx_byte(m_tx),
		.sda_out(serial_data_out),
		.sda_oe(serial_data_oe),
		.start_evt(m_start),
		.stop_evt(m_stop),
		.byte_evt(m_byte),
		.first_byte(m_first),
		.rx_byte(m_rx),
		.tx_done(m_done)
	);

	// address decode for the incoming first byte and the current pointer
	assign m_hit = match_map(m_rx[7:1], map_address);
	assign m_ofs = offset_to_map(m_ptr);
	assign m_wr = m_byte & ~m_first & ~m_need_sub & ~m_over;
	assign m_reg_we = m_wr & (m_map == i2c_maps_pkg::MAP_IO) & m_ofs[3];
	assign m_mem_we = m_wr & ~m_reg_we;

	// main port sequencing: select map, take subaddress, step pointer
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			m_ack <= 1'b0;
			m_map <= i2c_maps_pkg::MAP_IO;
			m_ptr <= i2c_maps_pkg::PTR_RESET;
			m_need_sub <= 1'b0;
			m_over <= 1'b0;
		end
		else if (ce)
		begin
			if (m_start || m_stop)
			begin
				m_ack <= 1'b0;
				m_over <= 1'b0;
			end
			else if (m_byte && m_first)
			begin
				// no match leaves the line released; the engine then idles
				m_ack <= m_hit[3];
				m_map <= m_hit[2:0];
				m_need_sub <= ~m_rx[0];
			end
			else if (m_byte && m_need_sub)
			begin
				m_ack <= (m_rx <= map_top(m_map));
				m_ptr <= m_rx;
				m_need_sub <= 1'b0;
			end
			else if (m_byte && m_over)
				m_ack <= 1'b0;
			else if (m_byte)
			begin
				m_ack <= 1'b1;
				if (m_ptr == map_top(m_map))
					m_over <= 1'b1;
				else
					m_ptr <= m_ptr + 8'h01;
			end
			else if (m_done && m_ptr != map_top(m_map))
				m_ptr <= m_ptr + 8'h01;
		end

	// read data: address registers shadow their io-map locations
	always_comb
	begin
		m_rd_byte = map_mem[{m_map, m_ptr}];
		if (m_map == i2c_maps_pkg::MAP_IO && m_ofs[3])
			m_rd_byte = {map_address[m_ofs[2:0]], i2c_maps_pkg::ADDR_PAD};
	end

	// ==========================================================
	// channel port engine: id data and protection area
	logic d_start;
	logic d_stop;
	logic d_byte;
	logic d_first;
	logic [7:0] d_rx;
	logic d_done;
	logic d_ack;
	logic [7:0] d_tx;
	logic [2:0] d_map;
	logic [7:0] d_ptr;
	logic d_need_sub;
	logic d_sub_set;
	logic d_over;
	logic d_id_hit;
	logic d_prot_hit;
	logic d_mem_we;

	serial_bit_engine channel_engine
	(
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.scl_pin(first_channel_port_clock),
		.sda_pin(first_channel_port_data_in),
		.ack_en(d_ack),
		.tx_byte(d_tx),
		.sda_out(first_channel_port_data_out),
		.sda_oe(first_channel_port_data_oe),
		.start_evt(d_start),
		.stop_evt(d_stop),
		.byte_evt(d_byte),
		.first_byte(d_first),
		.rx_byte(d_rx),
		.tx_done(d_done)
	);

	// fixed bus addresses of the two channel areas
	assign d_id_hit = (d_rx[7:1] == i2c_maps_pkg::CHANNEL_ID_ADDRESS);
	assign d_prot_hit = (d_rx[7:1] == i2c_maps_pkg::CHANNEL_PROTECT_ADDRESS);
	assign d_mem_we = d_byte & ~d_first & ~d_need_sub & ~d_over
		& (d_map == i2c_maps_pkg::MAP_REPEATER);

	// channel sequencing; the pointer doubles as the port's address counter
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			d_ack <= 1'b0;
			d_map <= i2c_maps_pkg::MAP_DISPLAY_ID;
			d_ptr <= i2c_maps_pkg::PTR_RESET;
			d_need_sub <= 1'b0;
			d_sub_set <= 1'b0;
			d_over <= 1'b0;
		end
		else if (ce)
		begin
			if (d_stop)
			begin
				// for the protection area a subaddress carries only into a repeated start, not a new frame; id data keeps its counter
				d_ack <= 1'b0;
				d_over <= 1'b0;
				d_sub_set <= 1'b0;
			end
			else if (d_start)
			begin
				d_ack <= 1'b0;
				d_over <= 1'b0;
			end
			else if (d_byte && d_first)
			begin
				d_ack <= d_id_hit | d_prot_hit;
				d_map <= d_prot_hit ? i2c_maps_pkg::MAP_REPEATER : i2c_maps_pkg::MAP_DISPLAY_ID;
				d_need_sub <= ~d_rx[0];
				// read with no subaddress: counter for id data, fixed start otherwise
				if (d_rx[0] && d_prot_hit && !d_sub_set)
					d_ptr <= i2c_maps_pkg::SHORT_READ_START;
			end
			else if (d_byte && d_need_sub)
			begin
				d_ack <= (d_rx <= map_top(d_map));
				d_ptr <= d_rx;
				d_sub_set <= 1'b1;
				d_need_sub <= 1'b0;
			end
			else if (d_byte && (d_over || d_map == i2c_maps_pkg::MAP_DISPLAY_ID))
				d_ack <= 1'b0;
			else if (d_byte)
			begin
				d_ack <= 1'b1;
				if (d_ptr == map_top(d_map))
					d_over <= 1'b1;
				else
					d_ptr <= d_ptr + 8'h01;
			end
			else if (d_done && d_ptr != map_top(d_map))
				d_ptr <= d_ptr + 8'h01;
		end

	// ==========================================================
	// read data staging for both engines; settles well before the next scl fall
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			m_tx <= i2c_maps_pkg::BYTE_RESET;
			d_tx <= i2c_maps_pkg::BYTE_RESET;
		end
		else if (ce)
		begin
			m_tx <= m_rd_byte;
			d_tx <= map_mem[{d_map, d_ptr}];
		end

	// ==========================================================
	// address registers: reset to zero so every programmable map starts silent
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			map_address <= {7{i2c_maps_pkg::ADDR_RESET}};
		else if (ce && m_reg_we)
			map_address[m_ofs[2:0]] <= m_rx[7:i2c_maps_pkg::ADDR_FIELD_LSB];

	// ==========================================================
	// byte store writes; single registers may be touched alone
	// limitation: a channel write in the very cycle of a main write is lost,
	// accepted because both pulses would have to land on the same clk edge
	always_ff @(posedge clk)
		if (ce)
		begin
			if (m_mem_we)
				map_mem[{m_map, m_ptr}] <= m_rx;
			else if (d_mem_we)
				map_mem[{i2c_maps_pkg::MAP_REPEATER, d_ptr}] <= d_rx;
		end
endmodule

// ===== dv/serial_master_model.sv
// master model for one two-wire port: conditions, bytes and acknowledge
// assumes: the bench resolves the open-drain wire; callers enter 1 ns after a clk edge
`timescale 1ns/100ps
module serial_master_model
(
	output logic scl,
	output logic sda_drive,
	input wire logic sda_line
);
	// ==========================================================
	// both lines released at idle; a low line would read as a start
	initial
	begin
		scl = 1'b1;
		sda_drive = 1'b1;
	end

	// one bit: data moves only while scl is low, sampled mid-high
	task automatic bit_io(input logic b, output logic got);
		sda_drive = b;
		#40 scl = 1'b1;
		#40 got = sda_line;
		#40 scl = 1'b0;
		#40;
	endtask

	// start or repeated start: data falls while the clock stays high
	task automatic start();
		sda_drive = 1'b1;
		#40 scl = 1'b1;
		#80 sda_drive = 1'b0;
		#80 scl = 1'b0;
		#40;
	endtask

	// stop: data rises while the clock stays high, then the bus is left idle
	task automatic stop();
		sda_drive = 1'b0;
		#40 scl = 1'b1;
		#80 sda_drive = 1'b1;
		#80;
	endtask

	// byte out msb first, then the ninth clock with the line released
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], g);
		bit_io(1'b1, g);
		ack = ~g;
	endtask

	// byte in; ackm low leaves the line high on the ninth clock to end a read
	task automatic get_byte(input logic ackm, output logic [7:0] d);
		logic g;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(~ackm, g);
	endtask
endmodule

// ===== dv/multi_map_i2c_slave_port_props.sv
// pin-level checker for the multi-map serial slave port
// assumes: masters move data only while the clock is low, apart from start and stop
`timescale 1ns/100ps
module multi_map_i2c_slave_port_props
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic serial_clock,
	input wire logic serial_data_in,
	input wire logic serial_data_out,
	input wire logic serial_data_oe,
	input wire logic first_channel_port_clock,
	input wire logic first_channel_port_data_in,
	input wire logic first_channel_port_data_out,
	input wire logic first_channel_port_data_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	logic prev_scl;
	logic prev_sda;
	logic [3:0] rise_cnt;
	logic start_seen;
	logic stop_seen;

	// ==========================================================
	// raw conditions on the main pins
	assign start_seen = serial_clock && prev_scl && prev_sda && !serial_data_in;
	assign stop_seen = serial_clock && prev_scl && !prev_sda && serial_data_in;

	// clock rises since the last start; 9 means no address phase in flight
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			prev_scl <= 1'b1;
			prev_sda <= 1'b1;
			rise_cnt <= 4'h9;
		end
		else
		begin
			prev_scl <= serial_clock;
			prev_sda <= serial_data_in;
			if (start_seen)
				rise_cnt <= 4'h0;
			else if (serial_clock && !prev_scl && rise_cnt < 4'h9)
				rise_cnt <= rise_cnt + 4'h1;
		end
	end

	// ==========================================================
	// open drain: the value behind the enable is always low
	property p_pin_low;
		!serial_data_out && !first_channel_port_data_out;
	endproperty
	a_pin_low: assert property (p_pin_low) else $error("data pin value not low");
	property p_ack_rise;
		$rose(serial_data_oe) |-> !serial_clock;
	endproperty
	a_ack_rise: assert property (p_ack_rise) else $error("pull-low began with clock high");
	property p_ack_fall;
		$fell(serial_data_oe) |-> !serial_clock;
	endproperty
	a_ack_fall: assert property (p_ack_fall) else $error("pull-low ended with clock high");
	property p_hold_high;
		$rose(serial_clock) |-> $stable(serial_data_oe) [*6];
	endproperty
	a_hold_high: assert property (p_hold_high) else $error("data moved in clock high");
	property p_addr_quiet;
		(rise_cnt < 4'h8) |-> !serial_data_oe;
	endproperty
	a_addr_quiet: assert property (p_addr_quiet) else $error("line driven in address bits");
	property p_stop_quiet;
		stop_seen |-> ##1 !serial_data_oe [*8];
	endproperty
	a_stop_quiet: assert property (p_stop_quiet) else $error("line driven after stop");
	property p_ch_rise;
		$rose(first_channel_port_data_oe) |-> !first_channel_port_clock;
	endproperty
	a_ch_rise: assert property (p_ch_rise) else $error("channel drive began clock high");
	property p_ch_fall;
		$fell(first_channel_port_data_oe) |-> !first_channel_port_clock;
	endproperty
	a_ch_fall: assert property (p_ch_fall) else $error("channel drive ended clock high");
	property p_ch_hold;
		$rose(first_channel_port_clock) |-> $stable(first_channel_port_data_oe) [*6];
	endproperty
	a_ch_hold: assert property (p_ch_hold) else $error("channel data moved clock high");
endmodule

bind multi_map_i2c_slave_port multi_map_i2c_slave_port_props u_props
(
	.clk(clk),
	.resetn(resetn),
	.serial_clock(serial_clock),
	.serial_data_in(serial_data_in),
	.serial_data_out(serial_data_out),
	.serial_data_oe(serial_data_oe),
	.first_channel_port_clock(first_channel_port_clock),
	.first_channel_port_data_in(first_channel_port_data_in),
	.first_channel_port_data_out(first_channel_port_data_out),
	.first_channel_port_data_oe(first_channel_port_data_oe)
);

// ===== dv/tb_multi_map_i2c_slave_port.sv
// self-checking bench: two master models drive the main and channel ports
// assumes: pull-ups on both data lines; ce held high throughout
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_multi_map_i2c_slave_port;
	logic clk;
	logic resetn;
	logic m_scl, m_drv, c_scl, c_drv;
	logic so, soe, co, coe;
	wire logic m_sda;
	wire logic c_sda;
	int n_mismatch = 0;
	int n_tests = 0;
	logic [7:0] ofs [7] = '{8'hF4, 8'hF5, 8'hF8, 8'hF9, 8'hFA, 8'hFB, 8'hFD};
	logic g;

	// ==========================================================
	// wired-and with pull-up: any enabled driver pulls the line low
	assign m_sda = m_drv & (soe ? so : 1'b1);
	assign c_sda = c_drv & (coe ? co : 1'b1);

	multi_map_i2c_slave_port uut (.clk(clk), .resetn(resetn), .ce(1'b1),
		.serial_clock(m_scl), .serial_data_in(m_sda), .serial_data_out(so),
		.serial_data_oe(soe), .first_channel_port_clock(c_scl),
		.first_channel_port_data_in(c_sda), .first_channel_port_data_out(co),
		.first_channel_port_data_oe(coe));
	serial_master_model mst_main (.scl(m_scl), .sda_drive(m_drv), .sda_line(m_sda));
	serial_master_model mst_chan (.scl(c_scl), .sda_drive(c_drv), .sda_line(c_sda));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ==========================================================
	// frames start 1 ns after an edge; model delays keep that offset
	task automatic start_on(input int p);
		@(posedge clk);
		#1;
		if (p == 0)
			mst_main.start();
		else
			mst_chan.start();
	endtask
	task automatic stop_on(input int p);
		if (p == 0)
			mst_main.stop();
		else
			mst_chan.stop();
	endtask
	task automatic put(input int p, input logic [7:0] b, input logic ea);
		logic a;
		if (p == 0)
			mst_main.put_byte(b, a);
		else
			mst_chan.put_byte(b, a);
		`CHK("ack", ea, a)
	endtask
	task automatic get(input int p, input logic ackm, input logic [7:0] e);
		logic [7:0] d;
		if (p == 0)
			mst_main.get_byte(ackm, d);
		else
			mst_chan.get_byte(ackm, d);
		`CHK("read data", e, d)
	endtask
	task automatic wr_reg(input int p, input logic [7:0] dev, sub, d);
		start_on(p);
		put(p, dev, 1'b1);
		put(p, sub, 1'b1);
		put(p, d, 1'b1);
		stop_on(p);
	endtask
	// combined frame: subaddress write, repeated start, one byte ended by nack
	task automatic rd_reg(input int p, input logic [7:0] dev, sub, e);
		start_on(p);
		put(p, dev, 1'b1);
		put(p, sub, 1'b1);
		start_on(p);
		put(p, {dev[7:1], 1'b1}, 1'b1);
		get(p, 1'b0, e);
		stop_on(p);
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// whole run is about 175 us of bus traffic
	initial
	begin
		#600000;
		n_mismatch++;
		stop_test;
	end

	// ==========================================================
	initial
	begin
		resetn = 1'b0;
		repeat (2) @(posedge clk);
		#1 resetn = 1'b1;
		repeat (3) @(posedge clk);
		foreach (ofs[i])
			rd_reg(0, 8'h98, ofs[i], 8'h00);
		$display("test reset_values done");
		start_on(0);
		put(0, 8'h60, 1'b0);
		stop_on(0);
		wr_reg(0, 8'h98, 8'hF8, 8'h61);
		rd_reg(0, 8'h98, 8'hF8, 8'h60);
		wr_reg(0, 8'h60, 8'h10, 8'hA5);
		rd_reg(0, 8'h60, 8'h10, 8'hA5);
		$display("test map_enable done");
		wr_reg(0, 8'h60, 8'h20, 8'h11);
		start_on(0);
		put(0, 8'h60, 1'b1);
		put(0, 8'h21, 1'b1);
		put(0, 8'h22, 1'b1);
		put(0, 8'h33, 1'b1);
		stop_on(0);
		start_on(0);
		put(0, 8'h60, 1'b1);
		put(0, 8'h20, 1'b1);
		start_on(0);
		put(0, 8'h61, 1'b1);
		get(0, 1'b1, 8'h11);
		get(0, 1'b1, 8'h22);
		get(0, 1'b0, 8'h33);
		stop_on(0);
		$display("test auto_increment done");
		start_on(0);
		put(0, 8'h60, 1'b1);
		put(0, 8'hFF, 1'b1);
		put(0, 8'h44, 1'b1);
		put(0, 8'h55, 1'b0);
		stop_on(0);
		start_on(0);
		put(0, 8'h60, 1'b1);
		put(0, 8'hFF, 1'b1);
		start_on(0);
		put(0, 8'h61, 1'b1);
		for (int k = 0; k < 3; k++)
			get(0, k < 2, 8'h44);
		stop_on(0);
		// read with no subaddress: pointer parked at the top register
		start_on(0);
		put(0, 8'h61, 1'b1);
		get(0, 1'b0, 8'h44);
		stop_on(0);
		$display("test top_boundary done");
		start_on(0);
		for (int k = 0; k < 4; k++)
			mst_main.bit_io(1'b1, g);
		stop_on(0);
		start_on(0);
		for (int k = 0; k < 3; k++)
			mst_main.bit_io(1'b0, g);
		start_on(0);
		put(0, 8'h60, 1'b1);
		put(0, 8'h10, 1'b1);
		start_on(0);
		put(0, 8'h61, 1'b1);
		get(0, 1'b0, 8'hA5);
		stop_on(0);
		$display("test abort done");
		wr_reg(1, 8'h74, 8'h08, 8'h5A);
		rd_reg(1, 8'h74, 8'h08, 8'h5A);
		start_on(1);
		put(1, 8'h75, 1'b1);
		get(1, 1'b0, 8'h5A);
		stop_on(1);
		// protection bytes are the repeater map's storage on the main port
		wr_reg(0, 8'h98, 8'hF9, 8'h64);
		rd_reg(0, 8'h64, 8'h08, 8'h5A);
		$display("test protect_area done");
		wr_reg(0, 8'h98, 8'hFA, 8'h62);
		start_on(0);
		put(0, 8'h62, 1'b1);
		put(0, 8'h00, 1'b1);
		put(0, 8'hC1, 1'b1);
		put(0, 8'hC2, 1'b1);
		stop_on(0);
		rd_reg(1, 8'hA0, 8'h00, 8'hC1);
		start_on(1);
		put(1, 8'hA1, 1'b1);
		get(1, 1'b0, 8'hC2);
		stop_on(1);
		start_on(1);
		put(1, 8'hA0, 1'b1);
		put(1, 8'h00, 1'b1);
		put(1, 8'h77, 1'b0);
		stop_on(1);
		rd_reg(1, 8'hA0, 8'h00, 8'hC1);
		$display("test id_area done");
		stop_test;
	end
endmodule
